//--- verilog/csp_regs.vh
// Register map, field positions, reset values and fixed counts of the
// converter serial port. Definitions only; included by csp_port.v.
`ifndef CSP_REGS_VH
`define CSP_REGS_VH

// Byte addresses on the APB bus
`define CSP_CTRL1_ADDR 12'h000
`define CSP_CTRL2_ADDR 12'h004
`define CSP_CTRL3_ADDR 12'h008
`define CSP_STAT_ADDR 12'h00C
`define CSP_RXBUF_ADDR 12'h010
`define CSP_TXBUF_ADDR 12'h020

// port_control_one fields
`define CSP_EN_BIT 0
`define CSP_FSDIR_BIT 1
`define CSP_MODE_LSB 2
`define CSP_IDLE_BIT 4
`define CSP_CTRL1_RST 5'h0_0

// port_control_two fields
`define CSP_CKDIR_BIT 0
`define CSP_WS_LSB 4
`define CSP_FSG_LSB 8
`define CSP_CTRL2_RST 12'h0_000

// Bit clock divider
`define CSP_BCG_RST 12'h0_000

// Frame sync modes
`define CSP_MODE_MULTI 2'h0
`define CSP_MODE_I2S 2'h1
`define CSP_MODE_AC16 2'h2
`define CSP_MODE_AC20 2'h3

// Fixed link figures: 16-bit slots, 16 slots, 16-bit sync high time
`define CSP_AC_WS 4'hF
`define CSP_AC_FSG 4'hF
`define CSP_SLOT_LAST 2'h3

`endif

//--- verilog/csp_port.v
// Converter serial port: APB registers, bit clock, frame sync, one shift
// register and a four-word shadow buffer per direction.
// Assumes pins pass through an external pad ring that resolves out/oe.
//
// The address map and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "csp_regs.vh"

// Functional notes
// - Enabled port owns all four pin directions
// - Bit clock pin direction follows direction bit
// - Data out pin driven while word transmits
// - Idle data out: low or released, selectable
// - Data in pin is input only
// - Frame sync delimits transfers, direction selectable
// - Engine uses shadow buffer, CPU its own
// - Buffer words held left-justified
// - Short receive words get zero low bits
// - Short transmit words ignore low bits
// - One 16-bit shift register, MSB first
// - Two-bit counter selects shadow word location
// - Receive address is zero then counter
// - Transmit address is one then counter
// - Single counter shared by both directions
// - Words to 16 bits, 16 slots per frame
// - Four words buffered each direction
// - Multi-channel, I2S and AC-link framing
// - Clearing enable resets counters except swap_cnt_reg, stops clocks
// - Word size field holds length minus one
// - Frame sync direction clear means master
module csp_port (
  input wire clock,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire serial_bit_clock_pin_in,
  output reg serial_bit_clock_pin_out,
  output reg serial_bit_clock_pin_oe,
  output reg serial_data_out_pin_out,
  output reg serial_data_out_pin_oe,
  input wire serial_data_in_pin_in,
  input wire frame_sync_pin_in,
  output reg frame_sync_pin_out,
  output reg frame_sync_pin_oe
);

  // Left-justify a received word of ws+1 bits, zero below it
  function [15:0] csp_justify;
    input [15:0] w;
    input [3:0] ws;
    begin
      csp_justify = w << (4'hF - ws);
    end
  endfunction

  // Master frame sync level for the bit about to be sent
  function csp_fs_level;
    input [1:0] mode;
    input [3:0] word;
    input [3:0] bitn;
    input [3:0] fsg;
    begin
      case (mode)
        `CSP_MODE_MULTI: csp_fs_level = (word == 4'h0) && (bitn == 4'h0);
        `CSP_MODE_I2S: csp_fs_level = ({1'b0, word} >= ({1'b0, fsg} + 5'h01) >> 1);
        default: csp_fs_level = (word == 4'h0);
      endcase
    end
  endfunction

  // Control registers
  reg port_enable_reg;
  reg frame_sync_direction_reg;
  reg [1:0] mode_reg;
  reg output_idle_mode_reg;
  reg bit_clock_direction_reg;
  reg [3:0] word_size_field_reg;
  reg [3:0] frame_len_reg;
  reg [11:0] bcg_reg;
  // CPU-visible buffers and the engine's shadow copy
  reg [15:0] cpu_tx_reg [0:3];
  reg [15:0] cpu_rx_reg [0:3];
  reg [15:0] shadow_reg [0:7];
  // Engine state
  reg [15:0] shift_reg;
  reg [1:0] slot_reg;
  reg [3:0] bit_cnt_reg;
  reg [3:0] word_cnt_reg;
  reg in_frame_reg;
  reg loaded_reg;
  reg fs_prev_reg;
  reg [7:0] swap_cnt_reg;
  reg [11:0] div_reg;
  reg sck_gen_reg;
  // Pin synchronisers
  reg sck_s1_reg, sck_s2_reg, sck_s3_reg;
  reg sdi_s1_reg, sdi_s2_reg;
  reg fs_s1_reg, fs_s2_reg;
  integer i;

  wire master_clk = !bit_clock_direction_reg;
  wire fs_master = !frame_sync_direction_reg;
  wire ac_mode = mode_reg[1];
  wire [3:0] ws_eff = ac_mode ? `CSP_AC_WS : word_size_field_reg;
  wire [3:0] fsg_eff = ac_mode ? `CSP_AC_FSG : frame_len_reg;
  wire gen_tick = (bcg_reg != 12'h0_000) && (div_reg == bcg_reg);
  // Edge events of whichever bit clock is in use
  wire bit_rise = master_clk ? (gen_tick && !sck_gen_reg) : (sck_s2_reg && !sck_s3_reg);
  wire bit_fall = master_clk ? (gen_tick && sck_gen_reg) : (!sck_s2_reg && sck_s3_reg);
  wire active = fs_master || in_frame_reg;
  wire word_done = bit_rise && active && loaded_reg && (bit_cnt_reg == ws_eff);
  wire [15:0] rx_word = csp_justify({shift_reg[14:0], sdi_s2_reg}, ws_eff);
  wire [2:0] tx_addr = {1'b1, slot_reg};
  wire [2:0] rx_addr = {1'b0, slot_reg};
  wire fs_edge = fs_s2_reg != fs_prev_reg;
  wire slave_start = (mode_reg == `CSP_MODE_I2S) ? fs_edge : fs_s2_reg;

  // APB decode; one wait state so read data leaves a flip-flop
  wire apb_acc = psel && penable;
  wire is_buf = (paddr[11:4] == 8'h01) || (paddr[11:4] == 8'h02);
  wire mapped = (paddr[1:0] == 2'h0) && ((paddr[11:4] == 8'h00) || is_buf);
  wire do_write = apb_acc && pready && pwrite && mapped;
  reg [31:0] rd_mux;

  // Read mux over all registers
  always @* begin
    rd_mux = 32'h0000_0000;
    case (paddr[11:4])
      8'h00: begin
        case (paddr[3:2])
          2'h0: rd_mux = {27'h000_0000, output_idle_mode_reg, mode_reg,
                          frame_sync_direction_reg, port_enable_reg};
          2'h1: rd_mux = {20'h0_0000, frame_len_reg, word_size_field_reg,
                          3'h0, bit_clock_direction_reg};
          2'h2: rd_mux = {20'h0_0000, bcg_reg};
          default: rd_mux = {8'h00, swap_cnt_reg, word_cnt_reg, bit_cnt_reg,
                             1'b0, loaded_reg, in_frame_reg, 1'b0, 2'h0, slot_reg};
        endcase
      end
      8'h01: rd_mux = {16'h0000, cpu_rx_reg[paddr[3:2]]};
      8'h02: rd_mux = {16'h0000, cpu_tx_reg[paddr[3:2]]};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // APB slave handshake and control register writes
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      port_enable_reg <= 1'b0;
      frame_sync_direction_reg <= 1'b0;
      mode_reg <= 2'h0;
      output_idle_mode_reg <= 1'b0;
      bit_clock_direction_reg <= 1'b0;
      word_size_field_reg <= 4'h0;
      frame_len_reg <= 4'h0;
      bcg_reg <= `CSP_BCG_RST;
      for (i = 0; i < 4; i = i + 1)
        cpu_tx_reg[i] <= 16'h0000;
    end else begin
      if (apb_acc && !pready) begin
        pready <= 1'b1;
        pslverr <= !mapped || (pwrite && paddr[11:4] == 8'h01) ||
                   (pwrite && paddr[11:2] == 10'h003);
        prdata <= mapped ? rd_mux : 32'h0000_0000;
      end else begin
        pready <= 1'b0;
        pslverr <= 1'b0;
      end
      // Writes land only at the edge that completes the access
      if (do_write) begin
        if (paddr[11:2] == 10'h000) begin
          port_enable_reg <= pwdata[`CSP_EN_BIT];
          frame_sync_direction_reg <= pwdata[`CSP_FSDIR_BIT];
          mode_reg <= pwdata[`CSP_MODE_LSB +: 2];
          output_idle_mode_reg <= pwdata[`CSP_IDLE_BIT];
        end
        if (paddr[11:2] == 10'h001) begin
          bit_clock_direction_reg <= pwdata[`CSP_CKDIR_BIT];
          word_size_field_reg <= pwdata[`CSP_WS_LSB +: 4];
          frame_len_reg <= pwdata[`CSP_FSG_LSB +: 4];
        end
        if (paddr[11:2] == 10'h002)
          bcg_reg <= pwdata[11:0];
        // Low bits stored but never shifted out for short words
        if (paddr[11:4] == 8'h02)
          cpu_tx_reg[paddr[3:2]] <= pwdata[15:0];
      end
    end
  end

  // Pin synchronisers; first stages feed only second stages
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      sck_s1_reg <= 1'b0;
      sck_s2_reg <= 1'b0;
      sck_s3_reg <= 1'b0;
      sdi_s1_reg <= 1'b0;
      sdi_s2_reg <= 1'b0;
      fs_s1_reg <= 1'b0;
      fs_s2_reg <= 1'b0;
    end else begin
      sck_s1_reg <= serial_bit_clock_pin_in;
      sck_s2_reg <= sck_s1_reg;
      sck_s3_reg <= sck_s2_reg;
      sdi_s1_reg <= serial_data_in_pin_in;
      sdi_s2_reg <= sdi_s1_reg;
      fs_s1_reg <= frame_sync_pin_in;
      fs_s2_reg <= fs_s1_reg;
    end
  end

  // Bit clock divider: half period of bcg+1 clocks, stopped when disabled
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      div_reg <= 12'h0_000;
      sck_gen_reg <= 1'b0;
    end else if (!port_enable_reg || bcg_reg == 12'h0_000) begin
      div_reg <= 12'h0_000;
      sck_gen_reg <= 1'b0;
    end else if (gen_tick) begin
      div_reg <= 12'h0_000;
      sck_gen_reg <= !sck_gen_reg;
    end else begin
      div_reg <= div_reg + 12'h0_001;
    end
  end

  // Pin direction and pin output flops
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      serial_bit_clock_pin_out <= 1'b0;
      serial_bit_clock_pin_oe <= 1'b0;
      frame_sync_pin_oe <= 1'b0;
    end else begin
      // Disabled port leaves the pins to general port logic
      serial_bit_clock_pin_oe <= port_enable_reg && master_clk;
      serial_bit_clock_pin_out <= sck_gen_reg;
      frame_sync_pin_oe <= port_enable_reg && fs_master;
    end
  end

  // Serial engine: shift path, framing, shadow buffer and slot counter
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      shift_reg <= 16'h0000;
      slot_reg <= 2'h0;
      bit_cnt_reg <= 4'h0;
      word_cnt_reg <= 4'h0;
      in_frame_reg <= 1'b0;
      loaded_reg <= 1'b0;
      fs_prev_reg <= 1'b0;
      swap_cnt_reg <= 8'h00;
      serial_data_out_pin_out <= 1'b0;
      serial_data_out_pin_oe <= 1'b0;
      frame_sync_pin_out <= 1'b0;
      for (i = 0; i < 4; i = i + 1)
        cpu_rx_reg[i] <= 16'h0000;
      for (i = 0; i < 8; i = i + 1)
        shadow_reg[i] <= 16'h0000;
    end else if (!port_enable_reg) begin
      // Disable acts as a module reset of all counters except swap_cnt_reg
      slot_reg <= 2'h0;
      bit_cnt_reg <= 4'h0;
      word_cnt_reg <= 4'h0;
      in_frame_reg <= 1'b0;
      loaded_reg <= 1'b0;
      fs_prev_reg <= 1'b0;
      serial_data_out_pin_out <= 1'b0;
      serial_data_out_pin_oe <= 1'b0;
      frame_sync_pin_out <= 1'b0;
    end else begin
      // No word in flight: idle level at once, even before any bit clock edge
      if (!(active && loaded_reg)) begin
        serial_data_out_pin_out <= 1'b0;
        serial_data_out_pin_oe <= !output_idle_mode_reg;
      end
      // Transmit side changes on the falling bit clock edge
      if (bit_fall) begin
        if (active) begin
          if (bit_cnt_reg == 4'h0) begin
            shift_reg <= shadow_reg[tx_addr];
            serial_data_out_pin_out <= shadow_reg[tx_addr][15];
            loaded_reg <= 1'b1;
          end else begin
            serial_data_out_pin_out <= shift_reg[15];
          end
          serial_data_out_pin_oe <= 1'b1;
          if (fs_master)
            frame_sync_pin_out <= csp_fs_level(mode_reg, word_cnt_reg,
                                               bit_cnt_reg, fsg_eff);
        end else begin
          // Idle bit period: drive low or release the line
          serial_data_out_pin_out <= 1'b0;
          serial_data_out_pin_oe <= !output_idle_mode_reg;
        end
      end
      // Receive side samples on the rising bit clock edge
      if (bit_rise) begin
        fs_prev_reg <= fs_s2_reg;
        if (!fs_master && !in_frame_reg && slave_start)
          in_frame_reg <= 1'b1;
        if (active && loaded_reg) begin
          shift_reg <= {shift_reg[14:0], sdi_s2_reg};
          bit_cnt_reg <= bit_cnt_reg + 4'h1;
        end
        if (word_done) begin
          bit_cnt_reg <= 4'h0;
          slot_reg <= slot_reg + 2'h1;
          shadow_reg[rx_addr] <= rx_word;
          if (word_cnt_reg == fsg_eff) begin
            word_cnt_reg <= 4'h0;
            if (!fs_master) begin
              in_frame_reg <= 1'b0;
              loaded_reg <= 1'b0;
            end
          end else begin
            word_cnt_reg <= word_cnt_reg + 4'h1;
          end
          // After the fourth word hand buffers across in one edge
          if (slot_reg == `CSP_SLOT_LAST) begin
            swap_cnt_reg <= swap_cnt_reg + 8'h01;
            for (i = 0; i < 3; i = i + 1)
              cpu_rx_reg[i] <= shadow_reg[i];
            cpu_rx_reg[3] <= rx_word;
            for (i = 0; i < 4; i = i + 1)
              shadow_reg[4 + i] <= cpu_tx_reg[i];
          end
        end
      end
    end
  end

endmodule // csp_port
`default_nettype wire

//--- tb/csp_port_asserts.sv
// Checker for csp_port: APB answer timing and pin direction relations.
// Assumes it is bound to csp_port and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module csp_port_asserts (
  input wire clock,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire serial_bit_clock_pin_oe,
  input wire serial_data_out_pin_oe,
  input wire frame_sync_pin_oe
);
  logic [4:0] c1_reg;
  logic ckin_reg;
  logic [1:0] quiet_reg;
  wire wr_done = psel && penable && pready && pwrite && !pslverr;
  wire settled = quiet_reg == 2'h3;
  wire en = c1_reg[0] && settled;
  wire rx_area = paddr[11:4] == 8'h01;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // Shadow of control writes; pins settle a few cycles after each one
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      c1_reg <= 5'h00;
      ckin_reg <= 1'b0;
      quiet_reg <= 2'h3;
    end else if (wr_done && paddr == 12'h000) begin
      c1_reg <= pwdata[4:0];
      quiet_reg <= 2'h0;
    end else if (wr_done && paddr == 12'h004) begin
      ckin_reg <= pwdata[0];
      quiet_reg <= 2'h0;
    end else if (!settled) begin
      quiet_reg <= quiet_reg + 2'h1;
    end
  end
  ck_dir_a:
    assert property (en && ckin_reg |-> !serial_bit_clock_pin_oe)
    else $error("bit clock pin driven while set as input");
  fs_dir_a:
    assert property (en |-> frame_sync_pin_oe == !c1_reg[1])
    else $error("frame sync enable does not follow direction");
  idle_drive_a:
    assert property (en && !c1_reg[4] |-> serial_data_out_pin_oe)
    else $error("data out not driven in drive-low mode");
  disable_pins_a:
    assert property (!c1_reg[0] && settled |-> !(serial_bit_clock_pin_oe ||
      serial_data_out_pin_oe || frame_sync_pin_oe))
    else $error("pin driven while port disabled");
  wait_state_a:
    assert property (psel && $rose(penable) |=> pready)
    else $error("pready not one cycle after access");
  ready_pulse_a:
    assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  ro_write_a:
    assert property (pready && pwrite && (paddr == 12'h00C || rx_area) |-> pslverr)
    else $error("write to read-only place accepted");
  buf_upper_a:
    assert property (pready && !pwrite && (rx_area || paddr[11:4] == 8'h02)
      |-> prdata[31:16] == 16'h0000)
    else $error("buffer upper half not zero");
endmodule // csp_port_asserts
bind csp_port csp_port_asserts chk (.clock(clock), .rst(rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .serial_bit_clock_pin_oe(serial_bit_clock_pin_oe),
  .serial_data_out_pin_oe(serial_data_out_pin_oe),
  .frame_sync_pin_oe(frame_sync_pin_oe));
`default_nettype wire

//--- tb/csp_codec.sv
// Codec model: supplies bit clock and frame sync as the frame master.
// Assumes the port is a frame sync slave that takes the bit clock in.
`timescale 1ns/1ps
`default_nettype none
module csp_codec (
  output logic bclk,
  output logic fs,
  output logic din,
  input wire logic dout,
  input wire logic run,
  input wire logic [4:0] nbits,
  input wire logic [15:0] seed,
  output logic gap,
  output logic [63:0] cap,
  output int frames
);
  logic [15:0] word;
  // One idle bit with sync high, then four words MSB first
  initial begin
    bclk = 1'b0;
    fs = 1'b0;
    din = 1'b0;
    gap = 1'b0;
    cap = 64'h0000_0000_0000_0000;
    frames = 0;
    forever begin
      wait (run === 1'b1);
      #37;
      fs = 1'b1;
      din = ~din; // Released line shows no stale level
      cap = 64'h0000_0000_0000_0000;
      #80 bclk = 1'b1;
      gap = 1'b1;
      #80 bclk = 1'b0;
      gap = 1'b0;
      fs = 1'b0;
      for (int w = 0; w < 4; w++) begin
        word = seed + w * 16'h1357;
        for (int b = 0; b < nbits; b++) begin
          din = word[15 - b];
          #80 bclk = 1'b1;
          cap[16 * w + 15 - b] = dout;
          #80 bclk = 1'b0;
        end
      end
      frames++; // Clock stands still until the next frame
    end
  end
endmodule // csp_codec
`default_nettype wire

//--- tb/codec_serial_port_datapath_tb_top.sv
// Bench for csp_port: APB tasks and slave-mode frames with a codec model.
// Assumes csp_codec drives bit clock and frame sync from outside.
`timescale 1ns/1ps
`default_nettype none
module codec_serial_port_datapath_tb_top;
  logic clock = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic run = 0, dlast = 0, idle = 0, e;
  logic [4:0] nbits = 5'h10;
  logic [15:0] seed = 16'h0000;
  logic [31:0] r;
  wire [31:0] prdata;
  wire pready, pslverr, ck_out, ck_oe, dout_out, dout_oe, fs_out, fs_oe;
  wire bclk, fs, din, gap, dout_w;
  wire [63:0] cap;
  int frames;
  int num_errors = 0, n_tests = 0, cyc = 0;
  always #5 clock = ~clock;
  // Released data out shows the inverse of its last driven level
  always @(posedge clock) if (dout_oe) dlast <= dout_out;
  assign dout_w = dout_oe ? dout_out : ~dlast;
  csp_port DUT (.clock(clock), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .serial_bit_clock_pin_in(ck_oe ? ck_out : bclk),
    .serial_bit_clock_pin_out(ck_out), .serial_bit_clock_pin_oe(ck_oe),
    .serial_data_out_pin_out(dout_out), .serial_data_out_pin_oe(dout_oe),
    .serial_data_in_pin_in(din), .frame_sync_pin_in(fs_oe ? fs_out : fs),
    .frame_sync_pin_out(fs_out), .frame_sync_pin_oe(fs_oe));
  csp_codec codec (.bclk(bclk), .fs(fs), .din(din), .dout(dout_w), .run(run),
    .nbits(nbits), .seed(seed), .gap(gap), .cap(cap), .frames(frames));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Request held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 50);
    chk(n < 50, 1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(r, exp);
  endtask
  // Three frames after enable; the second carries the written words
  task automatic frames_run(input logic [3:0] ws, input logic id, input logic [15:0] sd);
    logic [15:0] m;
    int b;
    m = 16'hFFFF << (15 - ws);
    nbits = {1'b0, ws} + 5'h01;
    seed = sd;
    idle = id;
    for (int i = 0; i < 4; i++) apb(1'b1, 12'h020 + 4 * i, 16'h9AB0 + i * 16'h0F0F);
    apb(1'b1, 12'h004, {20'h0_0000, 4'h3, ws, 4'h1});
    apb(1'b1, 12'h000, {27'h000_0000, id, 4'h3});
    b = frames;
    run <= 1'b1;
    wait (frames == b + 2);
    run <= 1'b0;
    for (int i = 0; i < 4; i++) chk(cap[16 * i +: 16], (16'h9AB0 + i * 16'h0F0F) & m);
    wait (frames == b + 3);
    repeat (4) @(posedge clock);
    for (int i = 0; i < 4; i++) rd(12'h010 + 4 * i, (sd + i * 16'h1357) & m);
    apb(1'b1, 12'h000, 32'h0000_0000);
    repeat (8) @(posedge clock);
    $display("test frames ws %0d done", ws);
  endtask
  // Master frames: 4-bit words, two per frame, bit clock of 2*(4+1) clocks
  task automatic master_run;
    int t0, t1;
    apb(1'b1, 12'h008, 32'h0000_0004);
    apb(1'b1, 12'h004, 32'h0000_0130);
    apb(1'b1, 12'h000, 32'h0000_0001);
    @(posedge fs_out);
    t0 = cyc;
    @(posedge fs_out);
    t1 = cyc;
    chk(t1 - t0, 80);
    @(posedge ck_out);
    t0 = cyc;
    @(posedge ck_out);
    t1 = cyc;
    chk(t1 - t0, 10);
    chk(ck_oe & fs_oe & dout_oe, 1);
    apb(1'b1, 12'h000, 32'h0000_0000);
    repeat (4) @(posedge clock);
    chk({ck_oe, fs_oe, dout_oe, ck_out}, 0);
    $display("test master done");
  endtask
  // Idle data out between frames: released or driven low
  always @(posedge clock) if (gap) chk({dout_oe, dout_oe & dout_out}, {~idle, 1'b0});
  // Cycle ceiling cuts a hang short
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      report_and_stop;
    end
  end
  initial begin
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    for (int i = 0; i < 3; i++) rd(4 * i, 32'h0000_0000);
    rd(12'h100, 32'h0000_0000);
    chk(e, 1'b1);
    apb(1'b1, 12'h00C, 32'h0000_FFFF);
    chk(e, 1'b1);
    apb(1'b1, 12'h010, 32'h0000_FFFF);
    chk(e, 1'b1);
    rd(12'h010, 32'h0000_0000);
    for (int m = 0; m < 4; m++) apb(1'b1, 12'h000, 32'h0000_0010 | (m << 2));
    rd(12'h000, 32'h0000_001C);
    $display("test registers done");
    frames_run(4'hF, 1'b1, 16'hC3A5);
    frames_run(4'hB, 1'b0, 16'h2468);
    master_run;
    report_and_stop;
  end
endmodule // codec_serial_port_datapath_tb_top
`default_nettype wire
